// file: vectored_interrupt_priority.sv
// Functional notes
// - lower vector number means higher priority
// - high byte at lower address, low next
// - flag sets on event regardless of enable
// - request needs flag set and enable one
// - accept only when mask clear, after instruction
// - stack pc low, pc high, x, acc, condition
// - set mask, then fetch current top vector
// - vector 31 at FFC0, upward to 9 at FFEC
// - serial receive vectors OR four enabled conditions
// - serial error vectors OR four enabled errors
// - vector 22 shares three port change flags
// - vector 15 shares three flags, two enables
// - vector 0 reset, highest priority of all
// - global mask comes up set after reset
// - index high byte is never stacked
module vectored_interrupt_priority (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire vip_pkg::src_bus_t i_src,
   input wire logic [vip_pkg::N_EN-1:0] i_src_en,
   input wire logic i_instr_done,
   input wire logic i_mask_wr,
   input wire logic i_mask_wdata,
   input wire logic [7:0] i_fetch_data,
   output logic o_global_mask,
   output logic [vip_pkg::N_SRC-1:0] o_flags,
   output logic o_irq_pending,
   output logic [4:0] o_pend_vec,
   output logic [15:0] o_pend_addr,
   output logic o_entry_busy,
   output vip_pkg::entry_out_t o_entry
);

   vip_pkg::vip_state_t s_reg;
   vip_pkg::vip_state_t s_next;
   logic [vip_pkg::N_VEC-1:0] vec_req;
   logic sel_valid;
   logic [4:0] sel_vec;
   logic [15:0] sel_addr;

   // per-vector request: OR of every flag-and-enable pair mapped to it
   // spi transfer-done and mode-fault read the same enable lane
   // serial receive, serial error and port lanes fold the same way
   always_comb begin
      vec_req = '0;
      for (int i = 0; i < vip_pkg::N_SRC; i++) begin
         if (s_reg.flags[i] && i_src_en[vip_pkg::en_lane(i)]) begin
            vec_req[vip_pkg::SRC_VEC[i]] = 1'b1;
         end
      end
   end

   // lowest pending number wins, its slot address comes from the table
   vector_priority_select u_select (
      .i_req(vec_req),
      .o_valid(sel_valid),
      .o_vec(sel_vec),
      .o_addr(sel_addr)
   );

   // next-state logic for flags, mask, selector copy and entry sequence
   always_comb begin
      s_next = s_reg;
      s_next.isr_valid = 1'b0;
      // event wins over a clear in the same cycle
      s_next.flags = (s_reg.flags & ~i_src.clear) | i_src.event_hit;
      // refreshed every cycle so the core always sees the current winner
      s_next.pend_valid = sel_valid;
      s_next.pend_vec = sel_vec;
      s_next.pend_addr = sel_addr;
      // software mask writes are held off while the entry sequence runs
      if (i_mask_wr && (s_reg.state == vip_pkg::ST_IDLE)) begin
         s_next.global_mask = i_mask_wdata;
      end
      case (s_reg.state)
         vip_pkg::ST_IDLE: begin
            // take a request only at an instruction boundary, mask clear
            if (i_instr_done && s_reg.pend_valid && !s_reg.global_mask) begin
               s_next.state = vip_pkg::ST_PUSH_PC_LOW;
            end
         end
         vip_pkg::ST_PUSH_PC_LOW: begin
            s_next.state = vip_pkg::ST_PUSH_PC_HIGH;
         end
         vip_pkg::ST_PUSH_PC_HIGH: begin
            // the index high byte has no slot in this frame
            s_next.state = vip_pkg::ST_PUSH_X_LOW;
         end
         vip_pkg::ST_PUSH_X_LOW: begin
            s_next.state = vip_pkg::ST_PUSH_ACC;
         end
         vip_pkg::ST_PUSH_ACC: begin
            s_next.state = vip_pkg::ST_PUSH_COND;
         end
         vip_pkg::ST_PUSH_COND: begin
            s_next.state = vip_pkg::ST_SET_MASK;
         end
         vip_pkg::ST_SET_MASK: begin
            // mask set after stacking, vector picked from what pends now
            s_next.global_mask = 1'b1;
            s_next.fetch_addr = s_reg.pend_addr;
            s_next.state = vip_pkg::ST_FETCH_HIGH;
         end
         vip_pkg::ST_FETCH_HIGH: begin
            // high byte sits at the lower address of the slot
            s_next.isr_addr[15:8] = i_fetch_data;
            s_next.fetch_addr = 16'(s_reg.fetch_addr + vip_pkg::VEC_BYTE_STEP);
            s_next.state = vip_pkg::ST_FETCH_LOW;
         end
         vip_pkg::ST_FETCH_LOW: begin
            s_next.isr_addr[7:0] = i_fetch_data;
            s_next.isr_valid = 1'b1;
            s_next.state = vip_pkg::ST_IDLE;
         end
         default: begin
            s_next.state = vip_pkg::ST_IDLE;
         end
      endcase
   end

   // state register; mask comes up set so nothing is taken before setup
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg.flags <= '0;
         s_reg.global_mask <= 1'b1;
         s_reg.state <= vip_pkg::ST_IDLE;
         s_reg.pend_valid <= 1'b0;
         s_reg.pend_vec <= 5'h00;
         s_reg.pend_addr <= vip_pkg::RESET_VEC_ADDR;
         s_reg.fetch_addr <= vip_pkg::RESET_VEC_ADDR;
         s_reg.isr_valid <= 1'b0;
         s_reg.isr_addr <= 16'h0000;
      end else begin
         s_reg <= s_next;
      end
   end

   // stack strobe and register select decoded straight from the state flops
   always_comb begin
      o_entry.stack_push = 1'b1;
      case (s_reg.state)
         vip_pkg::ST_PUSH_PC_LOW: o_entry.stack_sel = vip_pkg::SEL_PC_LOW_BYTE;
         vip_pkg::ST_PUSH_PC_HIGH: o_entry.stack_sel = vip_pkg::SEL_PC_HIGH_BYTE;
         vip_pkg::ST_PUSH_X_LOW: o_entry.stack_sel = vip_pkg::SEL_X_LOW;
         vip_pkg::ST_PUSH_ACC: o_entry.stack_sel = vip_pkg::SEL_ACC;
         vip_pkg::ST_PUSH_COND: o_entry.stack_sel = vip_pkg::SEL_COND_CODE;
         default: begin
            o_entry.stack_sel = vip_pkg::SEL_NONE;
            o_entry.stack_push = 1'b0;
         end
      endcase
   end

   // fetch strobe and result; memory answers in the cycle of the strobe
   assign o_entry.fetch_rd = (s_reg.state == vip_pkg::ST_FETCH_HIGH) || (s_reg.state == vip_pkg::ST_FETCH_LOW);
   assign o_entry.fetch_addr = s_reg.fetch_addr;
   assign o_entry.isr_valid = s_reg.isr_valid;
   assign o_entry.isr_addr = s_reg.isr_addr;

   // status views
   assign o_global_mask = s_reg.global_mask;
   assign o_flags = s_reg.flags;
   assign o_irq_pending = s_reg.pend_valid;
   assign o_pend_vec = s_reg.pend_vec;
   assign o_pend_addr = s_reg.pend_addr;
   assign o_entry_busy = (s_reg.state != vip_pkg::ST_IDLE);

endmodule // vectored_interrupt_priority

// file: vip_pkg.sv
package vip_pkg;

   // vector numbering and table placement
   localparam int N_VEC = 32;
   localparam int N_SRC = 44;
   localparam int N_EN = 43;
   localparam logic [4:0] VEC_LOWEST_SERVED = 5'h09;
   localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_BYTE_STEP = 16'h0001;

   // source lanes of vector 15; transfer-done and mode-fault share one enable, tx-empty has its own
   localparam int SRC_XFER_DONE = 6;
   localparam int SRC_MODE_FAULT = 7;
   localparam int SRC_TX_EMPTY = 8;

   // vector number of each source lane, lane 43 first
   localparam logic [N_SRC-1:0][4:0] SRC_VEC = {
      5'h1F, 5'h1E, 5'h1D, 5'h1D, 5'h1D, 5'h1C, 5'h1B, 5'h1B, 5'h1A, 5'h19, 5'h18,
      5'h17, 5'h16, 5'h16, 5'h16, 5'h15, 5'h15, 5'h14, 5'h14, 5'h14, 5'h14,
      5'h13, 5'h13, 5'h13, 5'h13, 5'h12, 5'h12, 5'h11, 5'h11, 5'h11, 5'h11,
      5'h10, 5'h10, 5'h10, 5'h10, 5'h0F, 5'h0F, 5'h0F, 5'h0E, 5'h0D, 5'h0C,
      5'h0B, 5'h0A, 5'h09};

   // entry sequencer states
   typedef enum logic [8:0] {
      ST_IDLE         = 9'h001,
      ST_PUSH_PC_LOW  = 9'h002,
      ST_PUSH_PC_HIGH = 9'h004,
      ST_PUSH_X_LOW   = 9'h008,
      ST_PUSH_ACC     = 9'h010,
      ST_PUSH_COND    = 9'h020,
      ST_SET_MASK     = 9'h040,
      ST_FETCH_HIGH   = 9'h080,
      ST_FETCH_LOW    = 9'h100
   } entry_state_t;

   // which register the core must place on the stack
   typedef enum logic [2:0] {
      SEL_NONE         = 3'h0,
      SEL_PC_LOW_BYTE  = 3'h1,
      SEL_PC_HIGH_BYTE = 3'h2,
      SEL_X_LOW        = 3'h3,
      SEL_ACC          = 3'h4,
      SEL_COND_CODE    = 3'h5
   } stack_sel_t;

   // source lane to enable lane: lanes above transfer-done shift down by one
   function automatic int en_lane(input int src);
      en_lane = (src > SRC_XFER_DONE) ? src - 1 : src;
   endfunction

   // two-byte vector slot address, growing downward from the reset slot
   function automatic logic [15:0] vec_addr(input logic [4:0] vec);
      vec_addr = 16'(RESET_VEC_ADDR - {10'h000, vec, 1'b0});
   endfunction

   // request side of the block: per-source events and clears
   typedef struct packed {
      logic [N_SRC-1:0] event_hit;
      logic [N_SRC-1:0] clear;
   } src_bus_t;

   // entry sequence outputs toward the core
   typedef struct packed {
      logic stack_push;
      stack_sel_t stack_sel;
      logic fetch_rd;
      logic [15:0] fetch_addr;
      logic isr_valid;
      logic [15:0] isr_addr;
   } entry_out_t;

   // whole state of the top module
   typedef struct packed {
      logic [N_SRC-1:0] flags;
      logic global_mask;
      entry_state_t state;
      logic pend_valid;
      logic [4:0] pend_vec;
      logic [15:0] pend_addr;
      logic [15:0] fetch_addr;
      logic isr_valid;
      logic [15:0] isr_addr;
   } vip_state_t;

endpackage

// file: vector_priority_select.sv
// picks the lowest-numbered pending vector and its slot address
module vector_priority_select (
   input wire logic [vip_pkg::N_VEC-1:0] i_req,
   output logic o_valid,
   output logic [4:0] o_vec,
   output logic [15:0] o_addr
);

   // scan downward so the last hit is the lowest number
   always_comb begin
      o_valid = 1'b0;
      o_vec = 5'h00;
      for (int v = vip_pkg::N_VEC - 1; v >= 0; v--) begin
         if (i_req[v]) begin
            o_valid = 1'b1;
            o_vec = 5'(v);
         end
      end
      o_addr = vip_pkg::vec_addr(o_vec);
   end

endmodule // vector_priority_select

// file: vip_sva.sv
// watches the interrupt block from its ports only
module vip_sva (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire vip_pkg::src_bus_t i_src,
   input wire logic [vip_pkg::N_EN-1:0] i_src_en,
   input wire logic [7:0] i_fetch_data,
   input wire logic o_global_mask,
   input wire logic [vip_pkg::N_SRC-1:0] o_flags,
   input wire logic o_irq_pending,
   input wire logic [4:0] o_pend_vec,
   input wire logic [15:0] o_pend_addr,
   input wire logic o_entry_busy,
   input wire vip_pkg::entry_out_t o_entry
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // remaining four pushes after the pc low byte
   sequence s_stack;
      o_entry.stack_sel == 3'h2 ##1 o_entry.stack_sel == 3'h3 ##1 o_entry.stack_sel == 3'h4
         ##1 o_entry.stack_sel == 3'h5;
   endsequence
   property p_order;
      o_entry.stack_push && o_entry.stack_sel == 3'h1 |=> s_stack;
   endproperty
   a_order: assert property (p_order) else $error("stacking order broken");
   property p_mask;
      o_entry.stack_sel == 3'h5 |-> ##2 o_global_mask;
   endproperty
   a_mask: assert property (p_mask) else $error("mask not set after stacking");
   property p_hold;
      o_global_mask && !o_entry_busy |=> !o_entry_busy;
   endproperty
   a_hold: assert property (p_hold) else $error("entry while masked");
   // no disable here: the value during and just after reset is the point
   property p_rst;
      disable iff (1'b0) !i_rst_n |=> o_global_mask;
   endproperty
   a_rst: assert property (p_rst) else $error("mask clear after reset");
   property p_flag;
      (|i_src.event_hit) |=> (o_flags & $past(i_src.event_hit)) == $past(i_src.event_hit);
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set by event");
   property p_idle;
      o_flags == '0 |=> !o_irq_pending;
   endproperty
   a_idle: assert property (p_idle) else $error("request without flag");
   property p_pair;
      $rose(o_entry.fetch_rd) |=> o_entry.fetch_rd && o_entry.fetch_addr == $past(o_entry.fetch_addr) + 16'h0001;
   endproperty
   a_pair: assert property (p_pair) else $error("vector bytes not adjacent");
   property p_isr;
      $rose(o_entry.fetch_rd) |-> ##2 o_entry.isr_valid && o_entry.isr_addr == {$past(i_fetch_data, 2), $past(i_fetch_data)};
   endproperty
   a_isr: assert property (p_isr) else $error("service address byte order");
   property p_slot;
      o_irq_pending |-> o_pend_vec >= 5'h09 && o_pend_addr == 16'hFFFE - {10'h000, o_pend_vec, 1'b0};
   endproperty
   a_slot: assert property (p_slot) else $error("slot address wrong");
   property p_prio;
      o_flags[0] && i_src_en[0] |=> o_irq_pending && o_pend_vec == 5'h09;
   endproperty
   a_prio: assert property (p_prio) else $error("lowest vector lost");
endmodule // vip_sva
bind vectored_interrupt_priority vip_sva u_sva (.i_ref_clk, .i_rst_n, .i_src, .i_src_en, .i_fetch_data,
   .o_global_mask, .o_flags, .o_irq_pending, .o_pend_vec, .o_pend_addr, .o_entry_busy, .o_entry);

// file: core_model.sv
// processor side: instruction boundaries, vector memory, push count
module core_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire vip_pkg::entry_out_t i_entry,
   output logic o_instr_done,
   output logic [7:0] o_fetch_data,
   output int o_push_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cyc = 2'h0;
   int push_cnt = 0;
   // slow mode gives a boundary only every fourth cycle, like long instructions
   always @(posedge i_clk) begin
      cyc <= #2 cyc + 2'h1;
      if (i_entry.stack_push) begin
         push_cnt <= push_cnt + 1;
      end
   end
   // a single process owns the count, the port only shows it
   assign o_push_count = push_cnt;
   assign o_instr_done = !i_slow || cyc == 2'h3;
   // outside a read the bus wanders, so a stale byte cannot pass
   assign o_fetch_data = i_entry.fetch_rd ? i_entry.fetch_addr[7:0] ^ 8'h3C : {6'h00, cyc};
endmodule // core_model

// file: tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   vip_pkg::src_bus_t i_src = '0;
   logic [42:0] i_src_en = '0;
   logic i_mask_wr = 1'b0;
   logic i_mask_wdata = 1'b0;
   logic slow = 1'b0;
   logic i_instr_done, o_global_mask, o_irq_pending, o_entry_busy;
   logic [7:0] i_fetch_data;
   logic [43:0] o_flags;
   logic [4:0] o_pend_vec;
   logic [15:0] o_pend_addr;
   vip_pkg::entry_out_t o_entry;
   int bad_count = 0;
   int n_tests = 0;
   int pushes;
   always #12.5 i_ref_clk = ~i_ref_clk;
   vectored_interrupt_priority DUT (.i_ref_clk, .i_rst_n, .i_src, .i_src_en, .i_instr_done, .i_mask_wr,
      .i_mask_wdata, .i_fetch_data, .o_global_mask, .o_flags, .o_irq_pending, .o_pend_vec, .o_pend_addr,
      .o_entry_busy, .o_entry);
   core_model CORE (.i_clk(i_ref_clk), .i_slow(slow), .i_entry(o_entry), .o_instr_done(i_instr_done),
      .o_fetch_data(i_fetch_data), .o_push_count(pushes));
   // inputs always move 2 ns after the edge
   task step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #2;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task hit(input int k);
      i_src.event_hit[k] = 1'b1;
      step(1);
      i_src.event_hit[k] = 1'b0;
   endtask
   task clr_all;
      i_src.clear = '1;
      step(1);
      i_src.clear = '0;
      step(2);
   endtask
   task t_flag;
      hit(3);
      step(2);
      chk(16'(o_flags[3]), 16'h0001);
      chk(16'(o_irq_pending), 16'h0000);
      i_src_en[3] = 1'b1;
      step(2);
      chk(o_pend_addr, 16'hFFE6);
      i_src_en = '0;
      clr_all;
   endtask
   task t_prio;
      i_src_en = '1;
      i_src.event_hit = 44'h800_4000_0001;
      step(1);
      i_src.event_hit = '0;
      step(2);
      chk(o_pend_addr, 16'hFFEC);
      i_src.clear[0] = 1'b1;
      step(1);
      i_src.clear[0] = 1'b0;
      step(2);
      chk(o_pend_addr, 16'hFFD2);
      i_src.clear[30] = 1'b1;
      step(1);
      i_src.clear[30] = 1'b0;
      step(2);
      chk(o_pend_addr, 16'hFFC0);
      clr_all;
   endtask
   // all three lanes of vector 15 and the first and last lanes of vectors 16, 17, 19, 20 and 22, one at a time
   task t_shared;
      int ln[13] = '{6, 7, 8, 9, 12, 13, 16, 19, 22, 23, 26, 29, 31};
      int ev[13] = '{15, 15, 15, 16, 16, 17, 17, 19, 19, 20, 20, 22, 22};
      for (int k = 0; k < 13; k++) begin
         i_src_en = '0;
         i_src_en[ln[k] > 6 ? ln[k] - 1 : ln[k]] = 1'b1;
         hit(ln[k]);
         step(2);
         chk(16'(o_pend_vec), 16'(ev[k]));
         i_src_en = '0;
         step(2);
         chk(16'(o_irq_pending), 16'h0000);
         clr_all;
      end
   endtask
   // clears the mask, then keeps writing it while busy so drops are seen
   task enter(input logic [15:0] exp, input int np);
      int i;
      i_mask_wr = 1'b1;
      for (i = 0; i < 40; i++) begin
         step(1);
         if (o_entry.isr_valid === 1'b1) break;
         i_mask_wr = o_entry_busy;
      end
      i_mask_wr = 1'b0;
      if (i == 40) begin
         bad_count++;
         print_verdict;
      end
      chk(o_entry.isr_addr, exp);
      chk(16'(o_global_mask), 16'h0001);
      chk(16'(pushes), 16'(np));
   endtask
   initial begin
      step(10);
      i_rst_n = 1'b1;
      step(1);
      chk(16'(o_global_mask), 16'h0001);
      chk(o_pend_addr, 16'hFFFE);
      t_flag;
      t_prio;
      t_shared;
      i_src_en = '1;
      hit(30);
      step(2);
      enter(16'hEEEF, 5);
      step(4);
      chk(16'(o_entry_busy), 16'h0000);
      slow = 1'b1;
      hit(0);
      step(2);
      enter(16'hD0D1, 10);
      print_verdict;
   end
endmodule // tb_top
